/* File: rtl/serial_pkg.sv */
// Shared constants for the serial frame format and control block.
// Assumes a 32-bit AXI4-Lite register bus with one word per register.
package serial_pkg;
   // Register byte offsets on the bus
   localparam int unsigned ADDR_W = 5;
   localparam logic [4:0] OFF_FRAME = 5'h00;
   localparam logic [4:0] OFF_CTRL = 5'h04;
   localparam logic [4:0] OFF_TXBUF = 5'h08;
   localparam logic [4:0] OFF_FLAGS = 5'h0c;
   localparam logic [4:0] OFF_RXBUF = 5'h10;
   // Values after reset and after a low-power clear
   localparam logic [7:0] RST_FRAME = 8'h00;
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [7:0] RST_TXBUF = 8'hff;
   localparam logic [7:0] RST_RXBUF = 8'h00;
   // Frame format register fields
   localparam int unsigned FMT_SYNC = 7;
   localparam int unsigned FMT_CHR = 6;
   localparam int unsigned FMT_PE = 5;
   localparam int unsigned FMT_PM = 4;
   localparam int unsigned FMT_STOP = 3;
   localparam int unsigned FMT_MP = 2;
   // Serial control register fields
   localparam int unsigned CTL_TIE = 7;
   localparam int unsigned CTL_RIE = 6;
   localparam int unsigned CTL_TE = 5;
   localparam int unsigned CTL_RE = 4;
   localparam int unsigned CTL_TX_END_IRQ_ENABLE = 2;
   // Flags register fields
   localparam int unsigned FLG_TBE = 7;
   localparam int unsigned FLG_RBF = 6;
   localparam int unsigned FLG_OVR = 5;
   localparam int unsigned FLG_FER = 4;
   localparam int unsigned FLG_PER = 3;
   localparam int unsigned FLG_TEND = 2;
   // Prescaler select codes and divider terminal counts
   localparam logic [1:0] PS_SYS = 2'h0;
   localparam logic [1:0] PS_SUB = 2'h1;
   localparam logic [1:0] PS_DIV16 = 2'h2;
   localparam logic [1:0] PS_DIV64 = 2'h3;
   localparam logic [5:0] PS16_LAST = 6'h0f;
   localparam logic [5:0] PS64_LAST = 6'h3f;
   // Character lengths
   localparam logic [3:0] LEN8 = 4'h8;
   localparam logic [3:0] LEN7 = 4'h7;
   localparam logic [3:0] LEN5 = 4'h5;
   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Prescaler ticks per serial bit (bit-rate divider stands outside)
   localparam int unsigned BIT_TICKS_DEF = 4;
   typedef enum logic {TX_IDLE, TX_SHIFT} tx_state_e;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} rx_state_e;
endpackage

/* File: rtl/bit_sync.sv */
// Two-stage synchroniser for levels arriving from outside the clock domain.
// Assumes the input is a slow level; only the second stage is read.
`timescale 1ns/1ns
module bit_sync (
   input wire logic sys_clk_in,
   input wire logic rst_b_in,
   input wire logic d_in,
   output logic q_out
);
   logic meta; // First stage, read only by the second
   // Plain double flop, cleared to low at reset
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         meta <= 1'b0;
         q_out <= 1'b0;
      end else begin
         meta <= d_in;
         q_out <= meta;
      end
   end
endmodule

/* File: rtl/serial_frame_ctrl.sv */
// Serial port with frame format control, transmit/receive shifters and
// interrupt request outputs, reached over an AXI4-Lite slave port.
// Assumes one 10 MHz clock; the bit-rate divider sits outside (BIT_TICKS).
`timescale 1ns/1ns
//  Contract
// - Async: char select 0=8 bits, 1=7; sync 8
// - Seven-bit characters drop buffer bit 7
// - Parity plus multiproc gives five-bit characters
// - Async parity enable adds and checks parity
// - Even parity: total ones count even
// - Odd parity: total ones count odd
// - Stop select: one or two stops; sync none
// - Receiver checks only the first stop bit
// - Multiproc mode only affects async frames
// - Prescaler: clock, subclock, clock/16, clock/64
// - Subclock halved in active, full in sub
// - Control register always accessible, cleared low-power
// - Control register eight bits, fixed field order
// - Transmit-empty request when buffer empty flagged
// - Transmit-empty request drops with flag/enable
// - Receive enable gates full and error requests; code gates them with CTL_RIE, not CTL_RE
// - Receive-full request drops with flag/enable
// - Mode bit: 0 async at reset, 1 sync
// - No shifter load while buffer empty
module serial_frame_ctrl #(
   parameter int unsigned BIT_TICKS = serial_pkg::BIT_TICKS_DEF
) (
   input wire logic sys_clk_in,
   input wire logic rst_b_in,
   input wire logic awvalid_in,
   output logic awready_out,
   input wire logic [serial_pkg::ADDR_W-1:0] awaddr_in,
   input wire logic wvalid_in,
   output logic wready_out,
   input wire logic [31:0] wdata_in,
   input wire logic [3:0] wstrb_in,
   output logic bvalid_out,
   input wire logic bready_in,
   output logic [1:0] bresp_out,
   input wire logic arvalid_in,
   output logic arready_out,
   input wire logic [serial_pkg::ADDR_W-1:0] araddr_in,
   output logic rvalid_out,
   input wire logic rready_in,
   output logic [31:0] rdata_out,
   output logic [1:0] rresp_out,
   input wire logic rxd_in,
   output logic txd_out,
   output logic sck_out,
   input wire logic sub_clk_in,
   input wire logic sub_mode_in,
   input wire logic low_power_clear_in,
   output logic tx_empty_irq_out,
   output logic rx_full_irq_out,
   output logic rx_error_irq_out,
   output logic tx_end_irq_out
);
   import serial_pkg::*;

   localparam logic [7:0] TICK_LAST = 8'(BIT_TICKS - 1); // Last tick of a bit
   localparam logic [7:0] TICK_HALF = 8'(BIT_TICKS / 2 - 1); // Mid-bit tick

   // Pin inputs pass two flops first
   logic rxd_s, sub_s;
   bit_sync u_rxd_sync (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
      .d_in(rxd_in), .q_out(rxd_s));
   bit_sync u_sub_sync (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
      .d_in(sub_clk_in), .q_out(sub_s));

   // Register state
   logic [7:0] frame, ctrl, txbuf, rxbuf;
   logic tbe, rbf, ovr, framing_error_flag, parity_error_flag, tend;
   logic [7:0] next_frame, next_ctrl, next_txbuf, next_rxbuf;
   logic next_tbe, next_rbf, next_ovr, next_fer, next_per, next_tend;

   // Decoded frame format
   logic sync_mode, par_on, mpb_on, par_bit;
   logic [3:0] dlen, tx_len, rx_nbits;
   logic [7:0] dmask;
   always_comb begin
      sync_mode = frame[FMT_SYNC];
      if (sync_mode) dlen = LEN8;
      else if (frame[FMT_PE] && frame[FMT_MP]) dlen = LEN5;
      else if (frame[FMT_CHR]) dlen = LEN7;
      else dlen = LEN8;
      // Multiproc bit only exists in async frames; sync ignores it
      par_on = !sync_mode && frame[FMT_PE];
      mpb_on = !sync_mode && frame[FMT_MP] && !frame[FMT_PE];
      dmask = 8'hff >> (4'h8 - dlen);
      par_bit = (^(txbuf & dmask)) ^ frame[FMT_PM];
      if (sync_mode) tx_len = LEN8;
      else tx_len = 4'h2 + dlen + {3'h0, par_on | mpb_on} + {3'h0, frame[FMT_STOP]};
      // Only the first stop bit is sampled
      rx_nbits = sync_mode ? LEN8 : dlen + {3'h0, par_on | mpb_on} + 4'h1;
   end

   // Builds the outgoing frame, LSB first, idle ones filling the top
   function automatic logic [11:0] frame_of(input logic [7:0] d, input logic [3:0] dl,
         input logic sy, input logic pon, input logic pb, input logic mon);
      logic [11:0] v;
      v = 12'hfff; // Stop bits are the ones left above
      if (sy) begin
         v[7:0] = d;
      end else begin
         v[0] = 1'b0;
         for (int i = 0; i < 8; i++) begin
            if (4'(i) < dl) v[i+1] = d[i];
         end
         if (pon) v[4'(dl + 4'h1)] = pb;
         else if (mon) v[4'(dl + 4'h1)] = 1'b0;
      end
      return v;
   endfunction

   // Prescaler: picks the tick that clocks the bit counters
   logic [5:0] ps_cnt, next_ps_cnt;
   logic sub_prev, sub_half, next_sub_half, pre_tick, sub_rise;
   always_comb begin
      sub_rise = sub_s && !sub_prev;
      next_ps_cnt = ps_cnt + 6'h1;
      next_sub_half = sub_rise ? !sub_half : sub_half;
      case (frame[1:0])
         PS_SYS: pre_tick = 1'b1;
         // Active mode takes every second subclock edge
         PS_SUB: pre_tick = sub_rise && (sub_mode_in || sub_half);
         PS_DIV16: pre_tick = (ps_cnt[3:0] == PS16_LAST[3:0]);
         PS_DIV64: pre_tick = (ps_cnt == PS64_LAST);
         default: pre_tick = 1'b0;
      endcase
   end
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ps_cnt <= 6'h0;
         sub_prev <= 1'b0;
         sub_half <= 1'b0;
      end else begin
         ps_cnt <= next_ps_cnt;
         sub_prev <= sub_s;
         sub_half <= next_sub_half;
      end
   end

   // Transmitter
   tx_state_e tx_state, next_tx_state;
   logic [11:0] tx_sh, next_tx_sh;
   logic [3:0] tx_cnt, next_tx_cnt;
   logic [7:0] tx_tick, next_tx_tick;
   logic tx_load, next_txd, next_sck;
   always_comb begin
      next_tx_state = tx_state;
      next_tx_sh = tx_sh;
      next_tx_cnt = tx_cnt;
      next_tx_tick = tx_tick;
      // Loading needs fresh data; an empty buffer holds the shifter
      tx_load = (tx_state == TX_IDLE) && ctrl[CTL_TE] && !tbe && !low_power_clear_in;
      if (low_power_clear_in || !ctrl[CTL_TE]) begin
         next_tx_state = TX_IDLE;
      end else if (tx_load) begin
         next_tx_state = TX_SHIFT;
         next_tx_sh = frame_of(txbuf & dmask, dlen, sync_mode, par_on, par_bit, mpb_on);
         next_tx_cnt = tx_len;
         next_tx_tick = 8'h0;
      end else if (tx_state == TX_SHIFT && pre_tick) begin
         next_tx_tick = tx_tick + 8'h1;
         if (tx_tick == TICK_LAST) begin
            next_tx_tick = 8'h0;
            next_tx_sh = {1'b1, tx_sh[11:1]};
            next_tx_cnt = tx_cnt - 4'h1;
            if (tx_cnt == 4'h1) next_tx_state = TX_IDLE;
         end
      end
      next_txd = (next_tx_state == TX_SHIFT) ? next_tx_sh[0] : 1'b1;
      // Sync clock goes low for the first half of each bit
      next_sck = !(next_tx_state == TX_SHIFT && sync_mode && next_tx_tick <= TICK_HALF);
   end
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         tx_state <= TX_IDLE;
         tx_sh <= 12'hfff;
         tx_cnt <= 4'h0;
         tx_tick <= 8'h0;
         txd_out <= 1'b1;
         sck_out <= 1'b1;
      end else begin
         tx_state <= next_tx_state;
         tx_sh <= next_tx_sh;
         tx_cnt <= next_tx_cnt;
         tx_tick <= next_tx_tick;
         txd_out <= next_txd;
         sck_out <= next_sck;
      end
   end

   // Receiver: async samples mid-bit, sync samples at each bit end
   rx_state_e rx_state, next_rx_state;
   logic [9:0] rx_sh, next_rx_sh, rx_all;
   logic [3:0] rx_cnt, next_rx_cnt;
   logic [7:0] rx_tick, next_rx_tick, rx_word;
   logic rx_done, rx_ferr, rx_perr;
   always_comb begin
      next_rx_state = rx_state;
      next_rx_sh = rx_sh;
      next_rx_cnt = rx_cnt;
      next_rx_tick = rx_tick;
      rx_done = 1'b0;
      rx_all = {rxd_s, rx_sh[9:1]} >> (4'ha - rx_nbits);
      rx_word = rx_all[7:0] & dmask;
      rx_ferr = !sync_mode && !rx_all[4'(rx_nbits - 4'h1)];
      rx_perr = par_on && ((^rx_word) ^ rx_all[dlen]) != frame[FMT_PM];
      if (low_power_clear_in || !ctrl[CTL_RE]) begin
         next_rx_state = RX_IDLE;
      end else begin
         case (rx_state)
            RX_IDLE: begin
               next_rx_tick = 8'h0;
               next_rx_cnt = rx_nbits;
               if (sync_mode) next_rx_state = RX_DATA;
               else if (!rxd_s) next_rx_state = RX_START;
            end
            RX_START: if (pre_tick) begin
               next_rx_tick = rx_tick + 8'h1;
               if (rx_tick == TICK_HALF) begin
                  // A start bit gone high by mid-bit was noise
                  next_rx_state = rxd_s ? RX_IDLE : RX_DATA;
                  next_rx_tick = 8'h0;
               end
            end
            RX_DATA: if (pre_tick) begin
               next_rx_tick = rx_tick + 8'h1;
               if (rx_tick == TICK_LAST) begin
                  next_rx_tick = 8'h0;
                  next_rx_sh = {rxd_s, rx_sh[9:1]};
                  next_rx_cnt = rx_cnt - 4'h1;
                  if (rx_cnt == 4'h1) begin
                     rx_done = 1'b1;
                     next_rx_state = RX_IDLE;
                  end
               end
            end
            default: next_rx_state = RX_IDLE;
         endcase
      end
   end
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rx_state <= RX_IDLE;
         rx_sh <= 10'h0;
         rx_cnt <= 4'h0;
         rx_tick <= 8'h0;
      end else begin
         rx_state <= next_rx_state;
         rx_sh <= next_rx_sh;
         rx_cnt <= next_rx_cnt;
         rx_tick <= next_rx_tick;
      end
   end

   // AXI4-Lite slave: address and data latch in either order
   logic aw_held, w_held, next_aw_held, next_w_held, wr_fire, next_bvalid;
   logic [4:0] aw_addr, next_aw_addr;
   logic [7:0] w_byte, next_w_byte;
   logic w_lane0, next_w_lane0, next_rvalid;
   logic [1:0] next_bresp, next_rresp;
   logic [31:0] next_rdata;
   always_comb begin
      awready_out = !aw_held && !bvalid_out;
      wready_out = !w_held && !bvalid_out;
      arready_out = !rvalid_out;
      next_aw_held = aw_held || (awvalid_in && awready_out);
      next_aw_addr = (awvalid_in && awready_out) ? awaddr_in : aw_addr;
      next_w_held = w_held || (wvalid_in && wready_out);
      next_w_byte = (wvalid_in && wready_out) ? wdata_in[7:0] : w_byte;
      next_w_lane0 = (wvalid_in && wready_out) ? wstrb_in[0] : w_lane0;
      wr_fire = aw_held && w_held && !bvalid_out;
      next_bvalid = bvalid_out ? !bready_in : wr_fire;
      next_bresp = bresp_out;
      if (wr_fire) begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bresp = (aw_addr > OFF_RXBUF || aw_addr[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY;
      end
      next_rvalid = rvalid_out ? !rready_in : arvalid_in;
      next_rdata = rdata_out;
      next_rresp = rresp_out;
      if (arvalid_in && arready_out) begin
         next_rdata = 32'h0;
         next_rresp = RESP_OKAY;
         case (araddr_in)
            OFF_FRAME: next_rdata[7:0] = frame;
            OFF_CTRL: next_rdata[7:0] = ctrl;
            OFF_TXBUF: next_rdata[7:0] = txbuf;
            OFF_FLAGS: next_rdata[7:0] = {tbe, rbf, ovr, framing_error_flag, parity_error_flag, tend, 2'h0};
            OFF_RXBUF: next_rdata[7:0] = rxbuf;
            default: next_rresp = RESP_SLVERR;
         endcase
      end
   end
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 5'h0;
         w_byte <= 8'h0;
         w_lane0 <= 1'b0;
         bvalid_out <= 1'b0;
         bresp_out <= RESP_OKAY;
         rvalid_out <= 1'b0;
         rdata_out <= 32'h0;
         rresp_out <= RESP_OKAY;
      end else begin
         aw_held <= next_aw_held;
         w_held <= next_w_held;
         aw_addr <= next_aw_addr;
         w_byte <= next_w_byte;
         w_lane0 <= next_w_lane0;
         bvalid_out <= next_bvalid;
         bresp_out <= next_bresp;
         rvalid_out <= next_rvalid;
         rdata_out <= next_rdata;
         rresp_out <= next_rresp;
      end
   end

   // Registers and flags; hardware sets win over software clears
   logic wr_en;
   always_comb begin
      wr_en = wr_fire && w_lane0;
      next_frame = (wr_en && aw_addr == OFF_FRAME) ? w_byte : frame;
      next_ctrl = (wr_en && aw_addr == OFF_CTRL) ? w_byte : ctrl;
      next_txbuf = (wr_en && aw_addr == OFF_TXBUF) ? w_byte : txbuf;
      next_tbe = tbe && !(wr_en && aw_addr == OFF_TXBUF);
      next_tend = tend && !(wr_en && aw_addr == OFF_TXBUF);
      next_rbf = rbf;
      next_ovr = ovr;
      next_fer = framing_error_flag;
      next_per = parity_error_flag;
      next_rxbuf = rxbuf;
      if (wr_en && aw_addr == OFF_FLAGS) begin
         // Flags other than TEND clear on a written zero; ones leave them alone
         next_tbe = next_tbe && w_byte[FLG_TBE];
         next_rbf = rbf && w_byte[FLG_RBF];
         next_ovr = ovr && w_byte[FLG_OVR];
         next_fer = framing_error_flag && w_byte[FLG_FER];
         next_per = parity_error_flag && w_byte[FLG_PER];
      end
      if (tx_load || !ctrl[CTL_TE]) next_tbe = 1'b1;
      // Held off by a buffer write or load, so fresh data really clears it
      if (tx_state == TX_IDLE && tbe && next_tbe) next_tend = 1'b1;
      if (rx_done) begin
         if (rbf) begin
            next_ovr = 1'b1; // Old byte kept, new one lost
         end else begin
            next_rbf = 1'b1;
            next_rxbuf = rx_word;
            if (rx_ferr) next_fer = 1'b1;
            if (rx_perr) next_per = 1'b1;
         end
      end
      if (low_power_clear_in) begin
         next_frame = RST_FRAME;
         next_ctrl = RST_CTRL;
         next_txbuf = RST_TXBUF;
         next_rxbuf = RST_RXBUF;
         next_tbe = 1'b1;
         next_tend = 1'b1;
         next_rbf = 1'b0;
         next_ovr = 1'b0;
         next_fer = 1'b0;
         next_per = 1'b0;
      end
   end
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         frame <= RST_FRAME;
         ctrl <= RST_CTRL;
         txbuf <= RST_TXBUF;
         rxbuf <= RST_RXBUF;
         tbe <= 1'b1;
         tend <= 1'b1;
         rbf <= 1'b0;
         ovr <= 1'b0;
         framing_error_flag <= 1'b0;
         parity_error_flag <= 1'b0;
      end else begin
         frame <= next_frame;
         ctrl <= next_ctrl;
         txbuf <= next_txbuf;
         rxbuf <= next_rxbuf;
         tbe <= next_tbe;
         tend <= next_tend;
         rbf <= next_rbf;
         ovr <= next_ovr;
         framing_error_flag <= next_fer;
         parity_error_flag <= next_per;
      end
   end

   // Requests follow flag and enable, so clearing either drops them
   assign tx_empty_irq_out = ctrl[CTL_TIE] && tbe;
   assign rx_full_irq_out = ctrl[CTL_RIE] && rbf;
   assign rx_error_irq_out = ctrl[CTL_RIE] && (ovr || framing_error_flag || parity_error_flag);
   assign tx_end_irq_out = ctrl[CTL_TX_END_IRQ_ENABLE] && tend;

   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!rst_b_in);
   a_sync_len_eight: assert property (tx_load && sync_mode |=> tx_cnt == LEN8)
      else $error("sync frame not eight bits");
   a_seven_bit_msb: assert property (tx_load && !sync_mode && frame[6:5] == 2'h2
         && !frame[FMT_MP] |=> tx_sh[8] == 1'b1 && tx_sh[7:1] == $past(txbuf[6:0]))
      else $error("seven-bit frame carries bit seven");
   a_five_bit_frame: assert property (tx_load && !sync_mode && frame[FMT_PE]
         && frame[FMT_MP] |=> tx_sh[5:1] == $past(txbuf[4:0]))
      else $error("five-bit data wrong");
   a_parity_even: assert property (tx_load && frame[7:4] == 4'h2 && !frame[FMT_MP]
         |=> !(^tx_sh[9:1]))
      else $error("even parity wrong");
   a_parity_odd: assert property (tx_load && frame[7:4] == 4'h3 && !frame[FMT_MP]
         |=> ^tx_sh[9:1])
      else $error("odd parity wrong");
   a_two_stops: assert property (tx_load && frame[7:2] == 6'h02
         |=> tx_cnt == 4'hb && tx_sh[11:9] == 3'h7)
      else $error("two stop bits missing");
   a_low_power_clear: assert property (low_power_clear_in |=> ctrl == RST_CTRL
         && frame == RST_FRAME)
      else $error("low-power clear missed");
   a_tx_empty_hold: assert property (tx_state == TX_IDLE && tbe && !low_power_clear_in
         |=> tx_state == TX_IDLE)
      else $error("shifter loaded from empty buffer");
   a_rx_full_irq: assert property (rx_done && !rbf && ctrl[CTL_RIE]
         && !low_power_clear_in && !wr_fire |=> rx_full_irq_out)
      else $error("receive-full request missing");
   a_rx_err_irq: assert property ((rx_done && rbf && ctrl[CTL_RIE] && !wr_fire)
         ##1 (!wr_fire && !low_power_clear_in) |-> rx_error_irq_out [*2])
      else $error("error request not held");
   c_async_load: cover property (tx_load && !sync_mode);
   c_sync_load: cover property (tx_load && sync_mode);
   c_rx_done: cover property (rx_done && !rx_ferr);
endmodule

/* File: verif/serial_peer.sv */
// Far-side serial port model: captures frames from the transmit pin and
// sends frames on the receive pin. Assumes prescale code 00 on the block.
`timescale 1ns/1ns
module serial_peer #(
   parameter int unsigned BIT_TICKS = 4
) (
   input wire logic sys_clk_in,
   input wire logic txd_in,
   input wire logic [3:0] ncap_in,
   output logic rxd_out,
   output logic [11:0] cap_out,
   output int frames_out
);
   // Line idles high, as a released receive pin does
   initial begin
      rxd_out = 1'b1;
      cap_out = 12'hfff;
      frames_out = 0;
   end
   // Start edge, then one sample mid-bit per bit, LSB first
   initial begin
      forever begin
         @(negedge txd_in);
         repeat (BIT_TICKS / 2) @(posedge sys_clk_in);
         for (int i = 0; i < ncap_in; i++) begin
            repeat (BIT_TICKS) @(posedge sys_clk_in);
            cap_out[i] = txd_in;
         end
         frames_out++;
      end
   end
   // One frame: start bit, then n bits LSB first (stop included)
   task automatic send(input logic [11:0] b, input int n);
      @(posedge sys_clk_in);
      rxd_out <= 1'b0;
      for (int i = 0; i < n; i++) begin
         repeat (BIT_TICKS) @(posedge sys_clk_in);
         rxd_out <= b[i];
      end
      repeat (BIT_TICKS) @(posedge sys_clk_in);
      rxd_out <= 1'b1;
   endtask
endmodule

/* File: verif/testbench.sv */
// Self-checking bench: registers over AXI4-Lite, frame shapes on the
// transmit pin, receive requests. Assumes serial_peer on the serial pins.
`timescale 1ns/1ns
module testbench;
   import serial_pkg::*;
   localparam int unsigned BT = 4; // Short bit time keeps frames cheap
   logic clk = 1'b0, rst_b = 1'b0, lpc = 1'b0, sub = 1'b0, smode = 1'b0;
   logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
   logic awr, wrdy, bv, arr, rv, txd, rxd, ti, ri, ei, sck, te;
   logic [4:0] awa = 5'h00, ara = 5'h00;
   logic [31:0] wd = 32'h0, rd, got;
   logic [1:0] bresp, rresp, resp;
   logic [11:0] cap;
   logic [3:0] ncap = 4'h0;
   logic [7:0] d;
   logic [31:0] seed = 32'h0001789e;
   logic [7:0] fmts [9] = '{8'h00, 8'h60, 8'h30, 8'h08, 8'h24, 8'h04, 8'h3c,
      8'h40, 8'h20};
   int frames, n, mismatches = 0, n_tests = 0, cyc = 0;
   serial_frame_ctrl #(.BIT_TICKS(BT)) serial_frame_ctrl_inst (
      .sys_clk_in(clk), .rst_b_in(rst_b), .awvalid_in(awv), .awready_out(awr),
      .awaddr_in(awa), .wvalid_in(wv), .wready_out(wrdy), .wdata_in(wd),
      .wstrb_in(4'hf), .bvalid_out(bv), .bready_in(br), .bresp_out(bresp),
      .arvalid_in(arv), .arready_out(arr), .araddr_in(ara), .rvalid_out(rv),
      .rready_in(rr), .rdata_out(rd), .rresp_out(rresp), .rxd_in(rxd),
      .txd_out(txd), .sck_out(sck), .sub_clk_in(sub), .sub_mode_in(smode),
      .low_power_clear_in(lpc), .tx_empty_irq_out(ti), .rx_full_irq_out(ri),
      .rx_error_irq_out(ei), .tx_end_irq_out(te));
   serial_peer #(.BIT_TICKS(BT)) serial_peer_inst (.sys_clk_in(clk), .txd_in(txd),
      .ncap_in(ncap), .rxd_out(rxd), .cap_out(cap), .frames_out(frames));
   initial begin
      forever #50 clk = ~clk;
   end
   // Hang guard, far above the few thousand cycles the run needs
   always @(posedge clk) begin
      cyc <= cyc + 1;
      sub <= cyc[2]; // Subclock runs free, eight cycles a period
      if (cyc == 30000) begin
         mismatches++;
         summarize();
      end
   end
   function automatic logic [7:0] rnd8();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   // Bits after the start bit: data, parity or multiproc bit, stops
   function automatic int flen(input logic [7:0] f);
      int l;
      l = (f[FMT_PE] & f[FMT_MP]) ? 5 : (f[FMT_CHR] ? 7 : 8);
      return l + int'(f[FMT_PE] | f[FMT_MP]) + 1 + int'(f[FMT_STOP]);
   endfunction
   function automatic logic [11:0] fbits(input logic [7:0] f, input logic [7:0] v);
      int l;
      logic [11:0] b;
      l = (f[FMT_PE] & f[FMT_MP]) ? 5 : (f[FMT_CHR] ? 7 : 8);
      b = 12'hfff;
      for (int i = 0; i < l; i++) b[i] = v[i];
      if (f[FMT_PE]) b[l] = ^(v & ~(8'hff << l)) ^ f[FMT_PM];
      else if (f[FMT_MP]) b[l] = 1'b0;
      return b;
   endfunction
   task automatic chk(input logic ok, input string m);
      n_tests++;
      if (ok !== 1'b1) begin
         mismatches++;
         $display("wrong value at %0t ns: %s", $time, m);
      end
   endtask
   // Write: both channels offered together, each dropped once taken
   task automatic bus_wr(input logic [4:0] a, input logic [7:0] v);
      @(posedge clk);
      awv <= 1'b1;
      wv <= 1'b1;
      awa <= a;
      wd <= {24'h0, v};
      br <= 1'b1;
      do begin
         @(posedge clk);
         if (awr) awv <= 1'b0;
         if (wrdy) wv <= 1'b0;
      end while (bv !== 1'b1);
      br <= 1'b0;
      resp = bresp;
   endtask
   task automatic bus_rd(input logic [4:0] a);
      @(posedge clk);
      arv <= 1'b1;
      ara <= a;
      rr <= 1'b1;
      do begin
         @(posedge clk);
         if (arr) arv <= 1'b0;
      end while (rv !== 1'b1);
      rr <= 1'b0;
      got = rd;
      resp = rresp;
   endtask
   task automatic rchk(input logic [4:0] a, input logic [31:0] e, input string m);
      bus_rd(a);
      chk(got === e && resp === RESP_OKAY, m);
   endtask
   // Start-bit length in cycles for a prescaler dividing by p
   task automatic plen(input logic [7:0] f, input int p);
      int t;
      t = 0;
      bus_wr(OFF_FRAME, f);
      bus_wr(OFF_TXBUF, 8'hff);
      while (txd !== 1'b0) @(posedge clk);
      while (txd === 1'b0) begin
         @(posedge clk);
         t++;
      end
      chk(t > (BT - 1) * p && t <= BT * p, "prescaler bit time");
   endtask
   task automatic summarize();
      $display("comparisons %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      rchk(OFF_FRAME, 32'h0, "frame reset");
      rchk(OFF_CTRL, 32'h0, "control reset");
      bus_rd(5'h14);
      chk(resp === RESP_SLVERR, "unmapped read");
      d = rnd8();
      bus_wr(OFF_CTRL, d);
      rchk(OFF_CTRL, {24'h0, d}, "control readback");
      chk(ti === d[CTL_TIE], "empty request follows enable");
      chk(te === d[CTL_TX_END_IRQ_ENABLE], "end request follows enable");
      @(posedge clk);
      lpc <= 1'b1;
      repeat (2) @(posedge clk);
      lpc <= 1'b0;
      rchk(OFF_CTRL, 32'h0, "low-power clear");
      $display("test registers done");
      // Nine async frame shapes, random data; gap lets the last stop finish
      bus_wr(OFF_CTRL, 8'h20);
      for (int k = 0; k < 9; k++) begin
         bus_wr(OFF_FRAME, fmts[k]);
         ncap <= 4'(flen(fmts[k]));
         d = rnd8();
         n = frames;
         bus_wr(OFF_TXBUF, d);
         while (frames == n) @(posedge clk);
         repeat (2 * BT) @(posedge clk);
         chk(((cap ^ fbits(fmts[k], d)) & ~(12'hfff << flen(fmts[k]))) === 12'h0,
             "frame bits");
      end
      // Sync frame: eight bits, sampled at each rising serial clock
      bus_wr(OFF_FRAME, 8'h80);
      d = rnd8();
      bus_wr(OFF_TXBUF, d);
      for (int i = 0; i < 8; i++) begin
         @(posedge sck);
         got[i] = txd;
      end
      chk(got[7:0] === d, "sync frame bits");
      // Start-bit length for the clock/16, clock/64 and subclock codes, both subclock modes
      plen(8'h02, 16);
      plen(8'h03, 64);
      plen(8'h01, 16);
      smode <= 1'b1;
      plen(8'h01, 8);
      $display("test transmit frames done");
      // Even parity receive: good byte, then a parity fault
      bus_wr(OFF_FRAME, 8'h20);
      bus_wr(OFF_CTRL, 8'h50);
      d = rnd8();
      serial_peer_inst.send({3'b011, ^d, d}, 10);
      for (int i = 0; i < 100 && ri !== 1'b1; i++) @(posedge clk);
      chk(ri === 1'b1 && ei === 1'b0, "receive full request");
      rchk(OFF_RXBUF, {24'h0, d}, "received byte");
      bus_wr(OFF_FLAGS, 8'h84);
      chk(ri === 1'b0, "full request withdrawn");
      serial_peer_inst.send({3'b011, ~^d, d}, 10);
      for (int i = 0; i < 100 && ei !== 1'b1; i++) @(posedge clk);
      chk(ei === 1'b1, "parity fault request");
      // Third byte while full: overrun, earlier byte kept
      serial_peer_inst.send({3'b011, ^d, ~d}, 10);
      repeat (2 * BT) @(posedge clk);
      rchk(OFF_FLAGS, 32'hec, "overrun flag");
      rchk(OFF_RXBUF, {24'h0, d}, "buffer kept on overrun");
      bus_wr(OFF_CTRL, 8'h10);
      chk(ei === 1'b0 && ri === 1'b0, "requests drop with enable");
      $display("test receive done");
      summarize();
   end
endmodule
